// [src/shc_top.sv]
/*
 * Host command handler: accepts command packets byte by byte, runs self-test,
 * offset compensation, sensor configuration and pass-through result framing,
 * and streams result packets into the status channel.
 * Assumes the sensor and bus engines answer on the result ports below and
 * that the status channel is always ready for a byte.
 */
// What this block does
// RULE_01: Pass-through result holds address, count, register.
// RULE_02: Read data from 0x0D, packet padded.
// RULE_03: Count field is true read count.
// RULE_04: Pass-through results echo mode, rate, config, address.
// RULE_05: Self-test request code 0x000B, length 4.
// RULE_06: Busy sensor self-test: error, no packet.
// RULE_07: Self-test result code 0x0006, length 8.
// RULE_08: Self-test outcome encoding 0,1,2,4,7,8,9.
// RULE_09: Offsets at 0x06, 0x08, 0x0A or zero.
// RULE_10: Accel offsets signed milli-g; gyro none.
// RULE_11: Compensation request code 0x000C, length 4.
// RULE_12: Compensation result code 0x0007, length 8.
// RULE_13: Compensation status 0, 0x65 or 0x23.
// RULE_14: Configure request code 0x000D, length 8.
// RULE_15: Zero rate turns the sensor off.
// RULE_16: Zero latency means immediate reporting.
// RULE_17: Rate rounded up to supported doubling series.
// RULE_18: Rate change applies after short delay.
// RULE_19: Power change raises meta event if enabled.
// RULE_20: New latency updates running timer at once.
// RULE_21: Latency nonzero to zero acts as flush.
// RULE_22: Pass-through header 0x0005, padded length.
// RULE_23: Completion byte 1 success, 2 I2C fail.
// RULE_24: One result packet after command completes.
`timescale 1ns/1ns
module shc_top
    import shc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_last,
    output logic stat_valid,
    output logic [7:0] stat_byte,
    output logic stat_last,
    output logic err_valid,
    output logic [7:0] err_code,
    output logic op_start,
    output logic [15:0] op_code,
    output logic [7:0] op_sensor,
    input wire logic [NUM_VSENS-1:0] phys_busy,
    input wire logic op_done,
    input wire logic [7:0] op_status,
    input wire logic op_is_accel,
    input wire logic [15:0] op_x,
    input wire logic [15:0] op_y,
    input wire logic [15:0] op_z,
    input wire logic pass_done,
    input wire logic pass_is_spi,
    input wire logic pass_ack_ok,
    input wire logic pass_read,
    input wire logic [15:0] pass_mode,
    input wire logic [15:0] pass_rate,
    input wire logic [7:0] pass_cfg,
    input wire logic [7:0] pass_addr,
    input wire logic [7:0] pass_reg,
    input wire logic [4:0] pass_count,
    input wire logic [7:0] pass_data [0:18],
    input wire logic meta_rate_en,
    input wire logic meta_power_en,
    output logic [NUM_VSENS-1:0] sensor_on,
    output logic [3:0] sensor_rate [0:NUM_VSENS-1],
    output logic [23:0] sensor_latency [0:NUM_VSENS-1],
    output logic latency_update,
    output logic flush_req,
    output logic meta_rate_event,
    output logic meta_power_event
);
    shc_state_t state, next_state;
    logic [7:0] req [0:11];
    logic [7:0] next_req [0:11];
    logic [3:0] req_cnt, next_req_cnt;
    logic [7:0] pkt [0:MAX_PKT-1];
    logic [7:0] next_pkt [0:MAX_PKT-1];
    logic [5:0] pkt_len, next_pkt_len;
    logic [5:0] send_idx, next_send_idx;
    logic next_stat_valid, next_stat_last, next_err_valid, next_op_start;
    logic [7:0] next_stat_byte, next_err_code;
    logic [15:0] next_op_code;
    logic [7:0] next_op_sensor;
    logic [NUM_VSENS-1:0] next_sensor_on;
    logic [3:0] next_sensor_rate [0:NUM_VSENS-1];
    logic [23:0] next_sensor_latency [0:NUM_VSENS-1];
    logic next_latency_update, next_flush_req, next_meta_rate, next_meta_power;
    logic [8:0] rate_timer, next_rate_timer;
    logic [2:0] rate_slot, next_rate_slot;
    logic [3:0] rate_pend, next_rate_pend;
    logic q_off;
    logic [3:0] q_index;
    logic [15:0] hdr_cmd;
    logic [2:0] vs;
    logic [5:0] body;

    shc_rate_quant u_quant (
        .rate_bits({req[8], req[7], req[6], req[5]}),
        .rate_off(q_off),
        .rate_index(q_index)
    );

    always_comb begin
        next_state = state;
        next_req = req;
        next_req_cnt = req_cnt;
        next_pkt = pkt;
        next_pkt_len = pkt_len;
        next_send_idx = send_idx;
        next_stat_valid = 1'b0;
        next_stat_byte = stat_byte;
        next_stat_last = 1'b0;
        next_err_valid = 1'b0;
        next_err_code = err_code;
        next_op_start = 1'b0;
        next_op_code = op_code;
        next_op_sensor = op_sensor;
        next_sensor_on = sensor_on;
        next_sensor_rate = sensor_rate;
        next_sensor_latency = sensor_latency;
        next_latency_update = 1'b0;
        next_flush_req = 1'b0;
        next_meta_rate = 1'b0;
        next_meta_power = 1'b0;
        next_rate_timer = rate_timer;
        next_rate_slot = rate_slot;
        next_rate_pend = rate_pend;
        hdr_cmd = {req[1], req[0]};
        vs = req[4][2:0];
        body = 6'h00;
        // Rate change lands after a fixed settle delay.
        if (rate_timer != 9'h000) begin
            next_rate_timer = rate_timer - 9'h001;
            if (rate_timer == 9'h001) begin
                next_sensor_rate[rate_slot] = rate_pend; // RULE_18
                next_meta_rate = meta_rate_en; // RULE_18
            end
        end
        unique case (state)
            SHC_IDLE: begin
                if (pass_done) begin
                    next_state = SHC_BUILD;
                    next_op_code = CMD_PASS;
                end else if (cmd_valid) begin
                    next_req[0] = cmd_byte;
                    next_req_cnt = 4'h1;
                    next_state = cmd_last ? SHC_IDLE : SHC_HDR;
                end
            end
            SHC_HDR: begin
                if (cmd_valid) begin
                    if (req_cnt < 4'hC) begin
                        next_req[req_cnt] = cmd_byte;
                    end
                    next_req_cnt = (req_cnt < 4'hC) ? req_cnt + 4'h1 : req_cnt;
                    if (cmd_last) begin
                        next_state = SHC_WAIT;
                    end
                end
            end
            SHC_WAIT: begin
                next_state = SHC_IDLE;
                next_op_sensor = req[4];
                if ((hdr_cmd == CMD_SELF_TEST || hdr_cmd == CMD_COMP)
                    && {req[3], req[2]} == LEN_SHORT_REQ) begin // RULE_05 RULE_11
                    if (hdr_cmd == CMD_SELF_TEST && phys_busy[req[4][2:0]]) begin
                        next_err_valid = 1'b1; // RULE_06
                        next_err_code = ERR_SENSOR_BUSY; // RULE_06
                    end else begin
                        next_op_start = 1'b1;
                        next_op_code = hdr_cmd;
                        next_state = SHC_BUILD;
                    end
                end else if (hdr_cmd == CMD_CONFIG
                    && {req[3], req[2]} == LEN_CONFIG_REQ) begin // RULE_14
                    next_sensor_on[vs] = !q_off; // RULE_15
                    next_meta_power = meta_power_en && (sensor_on[vs] == q_off); // RULE_19
                    if (!q_off) begin
                        next_rate_pend = q_index; // RULE_17
                        next_rate_slot = vs;
                        next_rate_timer = 9'(RATE_CHANGE_CYCLES); // RULE_18
                    end
                    next_sensor_latency[vs] = {req[11], req[10], req[9]}; // RULE_16 RULE_20
                    next_latency_update = 1'b1; // RULE_20
                    next_flush_req = (sensor_latency[vs] != 24'h00_0000)
                        && ({req[11], req[10], req[9]} == 24'h00_0000); // RULE_21
                end else begin
                    next_err_valid = 1'b1;
                    next_err_code = ERR_BAD_CMD;
                end
            end
            SHC_BUILD: begin
                for (int i = 0; i < MAX_PKT; i++) begin
                    next_pkt[i] = 8'h00;
                end
                if (op_code == CMD_PASS) begin
                    next_pkt[0] = STAT_PASS[7:0]; // RULE_22
                    next_pkt[1] = STAT_PASS[15:8];
                    body = 6'(PASS_HDR_LEN) + (pass_read ? {1'b0, pass_count} : 6'h00);
                    body = ((body + 6'h07) & 6'h3C) - 6'h04; // RULE_02 RULE_22
                    next_pkt[2] = {2'b00, body};
                    next_pkt[4] = (pass_is_spi || pass_ack_ok) ? DONE_OK : DONE_I2C_FAIL; // RULE_23
                    next_pkt[5] = pass_mode[7:0]; // RULE_04
                    next_pkt[6] = pass_mode[15:8];
                    next_pkt[7] = pass_rate[7:0];
                    next_pkt[8] = pass_rate[15:8];
                    next_pkt[9] = pass_cfg;
                    next_pkt[OFS_ADDR] = pass_addr; // RULE_01
                    next_pkt[OFS_COUNT] = {3'b000, pass_count}; // RULE_01 RULE_03
                    next_pkt[OFS_REG] = pass_reg; // RULE_01
                    if (pass_read) begin
                        for (int i = 0; i < 19; i++) begin
                            if (5'(i) < pass_count) begin
                                next_pkt[int'(OFS_DATA) + i] = pass_data[i]; // RULE_02
                            end
                        end
                    end
                    next_pkt_len = body + 6'h04;
                    next_send_idx = 6'h00;
                    next_state = SHC_SEND; // RULE_24
                end else if (op_done) begin
                    if (op_code == CMD_SELF_TEST) begin
                        next_pkt[0] = STAT_SELF_TEST[7:0]; // RULE_07
                        next_pkt[1] = STAT_SELF_TEST[15:8];
                    end else begin
                        next_pkt[0] = STAT_COMP[7:0]; // RULE_12
                        next_pkt[1] = STAT_COMP[15:8];
                    end
                    next_pkt[2] = LEN_RESULT[7:0]; // RULE_07 RULE_12
                    next_pkt[OFS_SENSOR] = op_sensor;
                    // Outcome codes are passed through as the engine reports them.
                    next_pkt[OFS_OUTCOME] = op_status; // RULE_08 RULE_13
                    if (op_code == CMD_COMP || (op_is_accel && op_status != ST_UNSUPPORTED
                        && op_status != ST_NO_DEVICE)) begin // RULE_09 RULE_10
                        next_pkt[OFS_X] = op_x[7:0];
                        next_pkt[OFS_X + 5'h01] = op_x[15:8];
                        next_pkt[OFS_Y] = op_y[7:0];
                        next_pkt[OFS_Y + 5'h01] = op_y[15:8];
                        next_pkt[OFS_Z] = op_z[7:0];
                        next_pkt[OFS_Z + 5'h01] = op_z[15:8];
                    end
                    next_pkt_len = 6'h0C;
                    next_send_idx = 6'h00;
                    next_state = SHC_SEND; // RULE_24
                end
            end
            SHC_SEND: begin
                next_stat_valid = 1'b1;
                next_stat_byte = pkt[send_idx[4:0]];
                next_stat_last = (send_idx == pkt_len - 6'h01);
                next_send_idx = send_idx + 6'h01;
                if (send_idx == pkt_len - 6'h01) begin
                    next_state = SHC_IDLE;
                end
            end
            default: next_state = SHC_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= SHC_IDLE;
            req <= '{default: 8'h00};
            req_cnt <= 4'h0;
            pkt <= '{default: 8'h00};
            pkt_len <= 6'h00;
            send_idx <= 6'h00;
            stat_valid <= 1'b0;
            stat_byte <= 8'h00;
            stat_last <= 1'b0;
            err_valid <= 1'b0;
            err_code <= 8'h00;
            op_start <= 1'b0;
            op_code <= 16'h0000;
            op_sensor <= 8'h00;
            sensor_on <= '0;
            sensor_rate <= '{default: 4'h0};
            sensor_latency <= '{default: 24'h00_0000};
            latency_update <= 1'b0;
            flush_req <= 1'b0;
            meta_rate_event <= 1'b0;
            meta_power_event <= 1'b0;
            rate_timer <= 9'h000;
            rate_slot <= 3'h0;
            rate_pend <= 4'h0;
        end else begin
            state <= next_state;
            req <= next_req;
            req_cnt <= next_req_cnt;
            pkt <= next_pkt;
            pkt_len <= next_pkt_len;
            send_idx <= next_send_idx;
            stat_valid <= next_stat_valid;
            stat_byte <= next_stat_byte;
            stat_last <= next_stat_last;
            err_valid <= next_err_valid;
            err_code <= next_err_code;
            op_start <= next_op_start;
            op_code <= next_op_code;
            op_sensor <= next_op_sensor;
            sensor_on <= next_sensor_on;
            sensor_rate <= next_sensor_rate;
            sensor_latency <= next_sensor_latency;
            latency_update <= next_latency_update;
            flush_req <= next_flush_req;
            meta_rate_event <= next_meta_rate;
            meta_power_event <= next_meta_power;
            rate_timer <= next_rate_timer;
            rate_slot <= next_rate_slot;
            rate_pend <= next_rate_pend;
        end
    end
endmodule

// [src/shc_pkg.sv]
/*
 * Constants for the sensor host command handler: command and status codes,
 * packet offsets, outcome codes and timing counts.
 * Assumes a 250 MHz clock and byte-wide command and status channels.
 */
package shc_pkg;
    localparam logic [15:0] CMD_SELF_TEST = 16'h000B;
    localparam logic [15:0] CMD_COMP = 16'h000C;
    localparam logic [15:0] CMD_CONFIG = 16'h000D;
    localparam logic [15:0] CMD_PASS = 16'h0001;
    localparam logic [15:0] STAT_PASS = 16'h0005;
    localparam logic [15:0] STAT_SELF_TEST = 16'h0006;
    localparam logic [15:0] STAT_COMP = 16'h0007;
    localparam logic [15:0] LEN_SHORT_REQ = 16'h0004;
    localparam logic [15:0] LEN_CONFIG_REQ = 16'h0008;
    localparam logic [15:0] LEN_RESULT = 16'h0008;
    localparam logic [7:0] PASS_HDR_LEN = 8'h09;
    localparam logic [4:0] OFS_ADDR = 5'h0A;
    localparam logic [4:0] OFS_COUNT = 5'h0B;
    localparam logic [4:0] OFS_REG = 5'h0C;
    localparam logic [4:0] OFS_DATA = 5'h0D;
    localparam logic [4:0] OFS_SENSOR = 5'h04;
    localparam logic [4:0] OFS_OUTCOME = 5'h05;
    localparam logic [4:0] OFS_X = 5'h06;
    localparam logic [4:0] OFS_Y = 5'h08;
    localparam logic [4:0] OFS_Z = 5'h0A;
    localparam logic [4:0] OFS_RATE = 5'h05;
    localparam logic [4:0] OFS_LAT = 5'h09;
    localparam logic [7:0] ST_PASS = 8'h00;
    localparam logic [7:0] ST_MULTI = 8'h07;
    localparam logic [7:0] ST_UNSUPPORTED = 8'h08;
    localparam logic [7:0] ST_NO_DEVICE = 8'h09;
    localparam logic [7:0] comp_success_code = 8'h00;
    localparam logic [7:0] comp_failure_code = 8'h65;
    localparam logic [7:0] unspecified_error_code = 8'h23;
    localparam logic [7:0] DONE_OK = 8'h01;
    localparam logic [7:0] DONE_I2C_FAIL = 8'h02;
    localparam logic [7:0] ERR_SENSOR_BUSY = 8'h01;
    localparam logic [7:0] ERR_BAD_CMD = 8'h02;
    localparam int NUM_RATES = 10;
    // Supported rates as float bit patterns: 1.5625 Hz doubling to 800 Hz.
    localparam logic [31:0] RATE_MIN_BITS = 32'h3FC8_0000;
    localparam logic [7:0] RATE_MIN_EXP = 8'h7F;
    localparam int RATE_CHANGE_DELAY_NS = 1000;
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int RATE_CHANGE_CYCLES = RATE_CHANGE_DELAY_NS / CLOCK_PERIOD_NS;
    localparam int MAX_PKT = 32;
    localparam int NUM_VSENS = 8;
    typedef enum logic [4:0] {
        SHC_IDLE = 5'b00001,
        SHC_HDR = 5'b00010,
        SHC_WAIT = 5'b00100,
        SHC_BUILD = 5'b01000,
        SHC_SEND = 5'b10000
    } shc_state_t;
endpackage

// [src/shc_rate_quant.sv]
/*
 * Rounds an IEEE single rate up to the supported doubling series.
 * Assumes a non-negative, finite rate; returns an index 0..9 and an off flag.
 */
`timescale 1ns/1ns
module shc_rate_quant
    import shc_pkg::*;
(
    input wire logic [31:0] rate_bits,
    output logic rate_off,
    output logic [3:0] rate_index
);
    logic [31:0] scaled;
    logic [8:0] steps;
    always_comb begin
        rate_off = (rate_bits[30:0] == 31'h0000_0000);
        // Divide by 1.5625 in the exponent domain by comparing the mantissa.
        scaled = rate_bits;
        steps = {1'b0, rate_bits[30:23]} - {1'b0, RATE_MIN_EXP};
        if (rate_bits[22:0] > RATE_MIN_BITS[22:0]) begin
            steps = steps + 9'h001;
        end
        if (rate_bits[30:0] <= RATE_MIN_BITS[30:0]) begin
            rate_index = 4'h0;
        end else if (steps >= 9'(NUM_RATES - 1)) begin
            rate_index = 4'(NUM_RATES - 1);
        end else begin
            rate_index = steps[3:0];
        end
        if (scaled[31]) begin
            rate_index = 4'h0;
        end
    end
endmodule

// [bench/shc_engine_model.sv]
/*
 * Behavioural sensor engine behind the command handler: answers op_start
 * with one op_done pulse after a set number of cycles, prompt or slow.
 * Assumes the bench sets status, sensor kind and delay before each command.
 */
`timescale 1ns/1ns
module shc_engine_model
    import shc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic op_start,
    input wire logic [7:0] set_status,
    input wire logic set_accel,
    input wire logic [7:0] set_delay,
    output logic op_done,
    output logic [7:0] op_status,
    output logic op_is_accel,
    output logic [15:0] op_x,
    output logic [15:0] op_y,
    output logic [15:0] op_z
);
    localparam logic [15:0] X_OFS = 16'hFF38;
    localparam logic [15:0] Y_OFS = 16'h0012;
    localparam logic [15:0] Z_OFS = 16'h8001;
    logic busy;
    logic [7:0] wait_cnt;
    always @(posedge clock) begin
        op_done <= 1'b0;
        if (rst) begin
            busy <= 1'b0;
        end else if (op_start) begin
            busy <= 1'b1;
            wait_cnt <= set_delay;
        end else if (busy && wait_cnt == 8'h00) begin
            busy <= 1'b0;
            op_done <= 1'b1;
        end else if (busy) begin
            wait_cnt <= wait_cnt - 8'h01;
        end
    end
    // Result fields show inverted junk outside op_done.
    assign op_status = op_done ? set_status : ~set_status;
    assign op_is_accel = op_done ? set_accel : ~set_accel;
    assign op_x = op_done ? X_OFS : ~X_OFS;
    assign op_y = op_done ? Y_OFS : ~Y_OFS;
    assign op_z = op_done ? Z_OFS : ~Z_OFS;
endmodule

// [bench/shc_top_sva.sv]
/*
 * Concurrent checks on the command handler ports.
 * Assumes pass_done only arrives while the handler is idle.
 */
`timescale 1ns/1ns
module shc_top_sva
    import shc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic stat_valid,
    input wire logic [7:0] stat_byte,
    input wire logic stat_last,
    input wire logic err_valid,
    input wire logic op_start,
    input wire logic [15:0] op_code,
    input wire logic [7:0] op_sensor,
    input wire logic [NUM_VSENS-1:0] phys_busy,
    input wire logic op_done,
    input wire logic pass_done,
    input wire logic pass_is_spi,
    input wire logic pass_ack_ok,
    input wire logic meta_rate_en,
    input wire logic meta_power_en,
    input wire logic meta_rate_event,
    input wire logic meta_power_event
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence hdr_s(logic [15:0] code, logic [7:0] len);
        stat_valid && stat_byte == code[7:0] ##1 stat_byte == code[15:8]
            ##1 stat_byte == len ##1 stat_byte == 8'h00;
    endsequence
    busy_reject_a: assert property (op_start && op_code == CMD_SELF_TEST
        |-> !phys_busy[op_sensor[2:0]]) else $error("self-test started on busy sensor");
    err_silent_a: assert property (err_valid |-> !stat_valid [*8])
        else $error("packet after rejected command");
    self_test_hdr_a: assert property (op_done && op_code == CMD_SELF_TEST
        |-> ##2 hdr_s(STAT_SELF_TEST, 8'h08)) else $error("self-test header wrong");
    comp_hdr_a: assert property (op_done && op_code == CMD_COMP
        |-> ##2 hdr_s(STAT_COMP, 8'h08)) else $error("compensation header wrong");
    result_end_a: assert property (op_done |-> ##13 stat_valid && stat_last)
        else $error("result packet end misplaced");
    pass_hdr_a: assert property (pass_done
        |-> ##3 stat_valid && stat_byte == 8'h05 ##1 stat_byte == 8'h00)
        else $error("pass-through header wrong");
    spi_done_a: assert property (pass_done && pass_is_spi |-> ##7 stat_byte == DONE_OK)
        else $error("spi completion byte wrong");
    nack_done_a: assert property (pass_done && !pass_is_spi && !pass_ack_ok
        |-> ##7 stat_byte == DONE_I2C_FAIL) else $error("nack completion byte wrong");
    burst_a: assert property ($rose(stat_valid) |-> stat_valid [*8])
        else $error("status bytes not back to back");
    power_gate_a: assert property (meta_power_event |-> meta_power_en)
        else $error("power event while disabled");
    rate_gate_a: assert property (meta_rate_event |-> meta_rate_en)
        else $error("rate event while disabled");
endmodule
bind shc_top shc_top_sva u_sva (.clock, .rst, .stat_valid, .stat_byte, .stat_last, .err_valid,
    .op_start, .op_code, .op_sensor, .phys_busy, .op_done, .pass_done, .pass_is_spi,
    .pass_ack_ok, .meta_rate_en, .meta_power_en, .meta_rate_event, .meta_power_event);

// [bench/tb.sv]
/*
 * Self-checking bench for the command handler: result packets, busy reject,
 * sensor configuration and pass-through framing.
 * Assumes the engine model answers every op_start.
 */
`timescale 1ns/1ns
module tb;
    import shc_pkg::*;
    typedef struct packed {logic [15:0] code; logic [7:0] st; logic acc; logic zero;} shc_row_t;
    shc_row_t rows [11] = '{'{CMD_SELF_TEST, ST_PASS, 1'b1, 1'b0},
        '{CMD_SELF_TEST, 8'h01, 1'b1, 1'b0}, '{CMD_SELF_TEST, 8'h02, 1'b1, 1'b0},
        '{CMD_SELF_TEST, 8'h04, 1'b1, 1'b0}, '{CMD_SELF_TEST, ST_MULTI, 1'b1, 1'b0},
        '{CMD_SELF_TEST, ST_UNSUPPORTED, 1'b1, 1'b1}, '{CMD_SELF_TEST, ST_NO_DEVICE, 1'b1, 1'b1},
        '{CMD_SELF_TEST, ST_PASS, 1'b0, 1'b1}, '{CMD_COMP, comp_success_code, 1'b1, 1'b0},
        '{CMD_COMP, comp_failure_code, 1'b1, 1'b0}, '{CMD_COMP, unspecified_error_code, 1'b1, 1'b0}};
    logic clock = 0, rst = 1, cmd_valid = 0, cmd_last = 0, pass_done = 0, pass_is_spi = 0;
    logic pass_ack_ok = 0, pass_read = 1, set_accel = 0, op_done, op_is_accel, op_start;
    logic stat_valid, stat_last, err_valid, latency_update, flush_req;
    logic meta_rate_event, meta_power_event, meta_rate_en = 1, meta_power_en = 1;
    logic [7:0] cmd_byte = 0, set_status = 0, set_delay = 0, op_status, stat_byte, err_code;
    logic [7:0] op_sensor, pass_cfg = 8'h87, pass_addr = 8'h29, pass_reg = 8'h3A, last_err;
    logic [15:0] op_code, op_x, op_y, op_z, pass_mode = 16'h1234, pass_rate = 16'h01F4;
    logic [4:0] pass_count = 0;
    logic [NUM_VSENS-1:0] phys_busy = 0, sensor_on;
    logic [7:0] pass_data [0:18];
    logic [3:0] sensor_rate [0:NUM_VSENS-1];
    logic [23:0] sensor_latency [0:NUM_VSENS-1];
    logic [7:0] pk [12], rx [32];
    int rx_n = 0, lasts = 0, errs = 0, flushes = 0, powers = 0, cycles = 0;
    int num_errors = 0, samples_checked = 0, rates = 0, lats = 0;
    shc_top u_dut (.clock, .rst, .cmd_valid, .cmd_byte, .cmd_last, .stat_valid, .stat_byte,
        .stat_last, .err_valid, .err_code, .op_start, .op_code, .op_sensor, .phys_busy, .op_done,
        .op_status, .op_is_accel, .op_x, .op_y, .op_z, .pass_done, .pass_is_spi, .pass_ack_ok,
        .pass_read, .pass_mode, .pass_rate, .pass_cfg, .pass_addr, .pass_reg, .pass_count,
        .pass_data, .meta_rate_en, .meta_power_en, .sensor_on, .sensor_rate, .sensor_latency,
        .latency_update, .flush_req, .meta_rate_event, .meta_power_event);
    shc_engine_model u_engine (.clock, .rst, .op_start, .set_status, .set_accel, .set_delay,
        .op_done, .op_status, .op_is_accel, .op_x, .op_y, .op_z);
    initial forever #2 clock = ~clock;
    // --------------------------------------------------------------
    // Output monitor and run limit.
    // --------------------------------------------------------------
    always @(posedge clock) begin
        cycles++;
        if (stat_valid && rx_n < 32) begin
            rx[rx_n] = stat_byte;
            rx_n++;
        end
        if (stat_last) lasts++;
        if (err_valid) begin
            errs++;
            last_err = err_code;
        end
        if (flush_req) flushes++;
        if (meta_power_event) powers++;
        if (meta_rate_event) rates++;
        if (latency_update) lats++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input int n);
        rx_n = 0;
        lasts = 0;
        for (int i = 0; i < n; i++) begin
            @(negedge clock);
            cmd_valid = 1;
            cmd_byte = pk[i];
            cmd_last = (i == n - 1);
        end
        @(negedge clock);
        cmd_valid = 0;
        cmd_last = 0;
    endtask
    task automatic wait_rx(input int n);
        for (int i = 0; i < 300 && rx_n < n; i++) @(negedge clock);
        repeat (4) @(negedge clock);
        chk(rx_n, n);
        chk(lasts, 1);
    endtask
    task automatic cfg(input logic [7:0] sid, input logic [31:0] rate, input logic [23:0] lat,
            input logic on, input logic [3:0] idx);
        pk = '{CMD_CONFIG[7:0], CMD_CONFIG[15:8], 8'h08, 8'h00, sid, rate[7:0], rate[15:8],
            rate[23:16], rate[31:24], lat[7:0], lat[15:8], lat[23:16]};
        send(12);
        repeat (RATE_CHANGE_CYCLES + 8) @(negedge clock);
        chk(sensor_on[sid[2:0]], on);
        chk(sensor_rate[sid[2:0]], idx);
        chk(sensor_latency[sid[2:0]], lat);
    endtask
    task automatic pass(input logic spi, input logic ok, input int n);
        int len = (12 + n) / 4 * 4;
        rx_n = 0;
        lasts = 0;
        pass_is_spi = spi;
        pass_ack_ok = ok;
        pass_count = n[4:0];
        pass_done = 1;
        @(negedge clock);
        pass_done = 0;
        wait_rx(4 + len);
        chk({rx[3], rx[2], rx[1], rx[0]}, {len[15:0], STAT_PASS});
        chk(rx[4], (spi || ok) ? DONE_OK : DONE_I2C_FAIL);
        chk({rx[8], rx[7], rx[6], rx[5]}, {pass_rate, pass_mode});
        chk({rx[12], rx[11], rx[10], rx[9]}, {pass_reg, 3'b000, pass_count, pass_addr, pass_cfg});
        for (int i = 0; i < n; i++) chk(rx[13 + i], pass_data[i]);
    endtask
    initial begin
        for (int i = 0; i < 19; i++) pass_data[i] = 8'hA0 + 8'(i);
        repeat (3) @(negedge clock);
        rst = 0;
        @(negedge clock);
        foreach (rows[r]) begin
            set_status = rows[r].st;
            set_accel = rows[r].acc;
            set_delay = r[0] ? 8'h14 : 8'h00;
            pk = '{rows[r].code[7:0], rows[r].code[15:8], 8'h04, 8'h00, 8'(r), 0, 0, 0, 0, 0, 0, 0};
            send(8);
            wait_rx(12);
            chk({rx[1], rx[0]}, rows[r].code == CMD_SELF_TEST ? STAT_SELF_TEST : STAT_COMP);
            chk({rx[5], rx[4], rx[3], rx[2]}, {rows[r].st, 8'(r), LEN_RESULT});
            chk({rx[7], rx[6]}, rows[r].zero ? 16'h0000 : 16'hFF38);
            chk({rx[11], rx[10], rx[9], rx[8]}, rows[r].zero ? 0 : 32'h8001_0012);
        end
        phys_busy = 8'h08;
        pk = '{CMD_SELF_TEST[7:0], 8'h00, 8'h04, 8'h00, 8'h03, 0, 0, 0, 0, 0, 0, 0};
        send(8);
        repeat (40) @(negedge clock);
        chk({errs[7:0], last_err, rx_n[7:0]}, {8'h01, ERR_SENSOR_BUSY, 8'h00});
        phys_busy = 0;
        cfg(8'h02, 32'h4040_0000, 24'h00_0005, 1'b1, 4'h1);
        cfg(8'h03, 32'h3F80_0000, 24'h00_0007, 1'b1, 4'h0);
        cfg(8'h04, 32'h3FCC_CCCD, 24'h00_0000, 1'b1, 4'h1);
        cfg(8'h05, 32'h4448_0000, 24'h00_0000, 1'b1, 4'h9);
        meta_rate_en = 0;
        cfg(8'h02, 32'h4448_0000, 24'h00_0000, 1'b1, 4'h9);
        cfg(8'h02, 32'h0000_0000, 24'h00_0000, 1'b0, 4'h9);
        chk(flushes, 1);
        chk(powers, 5);
        chk(rates, 4);
        chk(lats, 6);
        pass(1'b1, 1'b1, 3);
        pass(1'b0, 1'b0, 4);
        pass(1'b0, 1'b1, 0);
        pass(1'b0, 1'b1, 19);
        tally_and_finish();
    end
endmodule
